/* File: gpd_port.sv */
// Summary of operation
// - latch 0x12, direction 0x11 (read/write), pin sample 0x10 (read).
// - latch reads give latched bits; pin sample reads give pin levels.
// - dir bit 1 drives the pin push-pull to its latch bit; 0 makes input.
// - input pull-up on only for latch bit 1 with global disable at 0.
// - any reset tri-states all eight pins at once, clock or no clock.
// - pin levels pass a synchroniser before any read or peripheral use.
// - transmitter enabled: pin 1 drives tx data, direction bit ignored.
// - receiver enabled: pin 0 is input; latch bit 1 still pulls it up.
// - pin 7 carries the timer2 compare output while set as an output.
// - pin 6 feeds the 16-bit timer capture input whatever its direction bit.
// - pin 5 carries the timer1 compare A output while set as an output.
// - pin 4 carries the timer1 compare B output while set as an output.
// - the compare pins 7, 5 and 4 also carry the pwm waveforms.
// - sampled pins 3 and 2 are interrupt sources one and zero.
`timescale 1ns/1ps

module gpd_port
  import gpd_pkg::*;
#(
  parameter int NUM_PINS = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [GPD_ADDR_W-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [GPD_DATA_W-1:0] io_wdata,
  output logic [GPD_DATA_W-1:0] io_rdata,
  input wire logic global_pullup_disable,
  input wire logic usart_tx_en,
  input wire logic usart_tx_data,
  input wire logic usart_rx_en,
  output logic usart_rx_data,
  input wire logic timer2_compare_en,
  input wire logic timer2_compare_output,
  input wire logic timer1_compare_a_en,
  input wire logic timer1_compare_a_output,
  input wire logic timer1_compare_b_en,
  input wire logic timer1_compare_b_output,
  output logic capture_input_pin,
  output logic external_irq_one,
  output logic external_irq_zero,
  input wire logic [NUM_PINS-1:0] port_pin_in,
  output logic [NUM_PINS-1:0] port_pin_out,
  output logic [NUM_PINS-1:0] port_pin_oe,
  output logic [NUM_PINS-1:0] port_pin_pullup
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // alternate functions sit on fixed bits of a byte-wide register
  if (NUM_PINS != GPD_DATA_W) begin : g_bad_pins
    $error("gpd_port: the port is exactly one data byte wide");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] port_output_latch;
  logic [NUM_PINS-1:0] port_direction;
  logic [NUM_PINS-1:0] port_pin_sample;
  logic [NUM_PINS-1:0] alt_en;
  logic [NUM_PINS-1:0] alt_val;
  logic [NUM_PINS-1:0] dir_eff;
  logic [GPD_DATA_W-1:0] next_rdata;
  logic wr_latch;
  logic wr_dir;

  assign wr_latch = io_wr && (io_addr == GPD_OFS_OUT_LATCH);
  assign wr_dir = io_wr && (io_addr == GPD_OFS_DIRECTION);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // output latch; async reset so the pull-ups drop with the drivers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_output_latch <= GPD_RST_OUT_LATCH;
    end else if (wr_latch) begin
      port_output_latch <= io_wdata;
    end
  end

  // direction bits clear without a clock edge on reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_direction <= GPD_RST_DIRECTION;
    end else if (wr_dir) begin
      port_direction <= io_wdata;
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    case (io_addr)
      GPD_OFS_OUT_LATCH: next_rdata = port_output_latch;
      GPD_OFS_DIRECTION: next_rdata = port_direction;
      GPD_OFS_PIN_SAMPLE: next_rdata = port_pin_sample;
      default: next_rdata = GPD_UNMAPPED_RDATA;
    endcase
  end

  // read data is registered and held until the next read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= GPD_RST_RDATA;
    end else if (io_rd) begin
      io_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // input path
  // ----------------------------------------------------------------
  // pin sample is only ever read through the synchroniser; costs two
  // cycles of latency but keeps metastability out of the peripherals
  gpd_sync #(
    .WIDTH(NUM_PINS),
    .STAGES(GPD_SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(port_pin_in),
    .sync_out(port_pin_sample)
  );

  // peripherals see the synchronised levels
  assign usart_rx_data = port_pin_sample[GPD_BIT_RXD];
  assign capture_input_pin = port_pin_sample[GPD_BIT_CAPTURE];
  assign external_irq_zero = port_pin_sample[GPD_BIT_IRQ0];
  assign external_irq_one = port_pin_sample[GPD_BIT_IRQ1];

  // ----------------------------------------------------------------
  // alternate output selection
  // ----------------------------------------------------------------
  // compare outputs carry pwm waveforms too, so no mode split here
  always_comb begin
    alt_en = '0;
    alt_val = '0;
    alt_en[GPD_BIT_TXD] = usart_tx_en;
    alt_val[GPD_BIT_TXD] = usart_tx_data;
    alt_en[GPD_BIT_T2_CMP] = timer2_compare_en;
    alt_val[GPD_BIT_T2_CMP] = timer2_compare_output;
    alt_en[GPD_BIT_T1_CMPA] = timer1_compare_a_en;
    alt_val[GPD_BIT_T1_CMPA] = timer1_compare_a_output;
    alt_en[GPD_BIT_T1_CMPB] = timer1_compare_b_en;
    alt_val[GPD_BIT_T1_CMPB] = timer1_compare_b_output;
  end

  // effective direction: tx forces out, rx forces in, others as set
  always_comb begin
    dir_eff = port_direction;
    dir_eff[GPD_BIT_TXD] = port_direction[GPD_BIT_TXD]
                           | usart_tx_en;
    dir_eff[GPD_BIT_RXD] = port_direction[GPD_BIT_RXD]
                           & ~usart_rx_en;
  end

  // ----------------------------------------------------------------
  // pad drivers, one slice per pin
  // ----------------------------------------------------------------
  // reset gates the enables directly so the pins float even while
  // the clock is stopped; the peripheral enables may not be reset
  for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
    assign port_pin_oe[k] = rst_b & dir_eff[k];
    assign port_pin_out[k] = alt_en[k] ? alt_val[k]
                                       : port_output_latch[k];
    assign port_pin_pullup[k] = rst_b & ~dir_eff[k]
                              & port_output_latch[k]
                              & ~global_pullup_disable;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_reset_float: assert property (
    @(posedge clk) disable iff (!rst_b)
    ($rose(rst_b) && !usart_tx_en) |-> (port_pin_oe == '0))
    else $error("pins driven right after reset release");

  chk_dir_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_dir |=> (port_direction == $past(io_wdata)))
    else $error("direction write not stored");

  chk_latch_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    (io_rd && io_addr == GPD_OFS_OUT_LATCH && !io_wr)
    |=> (io_rdata == $past(port_output_latch)))
    else $error("latch read returned wrong value");

  chk_pin_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    (io_rd && io_addr == GPD_OFS_PIN_SAMPLE
     && $past(rst_b, 2) && $past(rst_b))
    |=> (io_rdata == $past(port_pin_in, 3)))
    else $error("pin read does not match pin three cycles back");

  chk_unmapped_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    (io_rd && io_addr != GPD_OFS_OUT_LATCH
     && io_addr != GPD_OFS_DIRECTION
     && io_addr != GPD_OFS_PIN_SAMPLE)
    |=> (io_rdata == GPD_UNMAPPED_RDATA))
    else $error("unmapped read not zero");

  chk_sync_delay: assert property (
    @(posedge clk) disable iff (!rst_b)
    ($past(rst_b, 2) && $past(rst_b))
    |-> (port_pin_sample == $past(port_pin_in, 2)))
    else $error("pin sample not two cycles behind pin");

  chk_plain_drive: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_dir |=> ((((port_pin_oe ^ $past(io_wdata)) & 8'h4C) == 8'h00)
    && ((port_pin_out & 8'h4C) == (port_output_latch & 8'h4C))))
    else $error("plain pin drive does not follow its bits");

  chk_pullup_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    port_pin_pullup == (~port_pin_oe & port_output_latch
                        & {NUM_PINS{~global_pullup_disable}}))
    else $error("pull-up does not follow latch and disable");

  chk_tx_force: assert property (
    @(posedge clk) disable iff (!rst_b)
    usart_tx_en |-> (port_pin_oe[GPD_BIT_TXD]
                     && port_pin_out[GPD_BIT_TXD] == usart_tx_data))
    else $error("transmit pin not forced out");

  chk_rx_force: assert property (
    @(posedge clk) disable iff (!rst_b)
    (usart_rx_en && $past(rst_b, 2) && $past(rst_b))
    |-> (!port_pin_oe[GPD_BIT_RXD]
         && usart_rx_data == $past(port_pin_in[GPD_BIT_RXD], 2)))
    else $error("receive pin not forced in");

  chk_timer2_pin: assert property (
    @(posedge clk) disable iff (!rst_b)
    (timer2_compare_en && port_direction[GPD_BIT_T2_CMP])
    |-> (port_pin_oe[GPD_BIT_T2_CMP]
         && port_pin_out[GPD_BIT_T2_CMP] == timer2_compare_output))
    else $error("timer2 compare not on its pin");

  chk_compare_ab: assert property (
    @(posedge clk) disable iff (!rst_b)
    (timer1_compare_a_en |-> port_pin_out[GPD_BIT_T1_CMPA]
                             == timer1_compare_a_output)
    and (timer1_compare_b_en |-> port_pin_out[GPD_BIT_T1_CMPB]
                                 == timer1_compare_b_output))
    else $error("timer1 compare outputs not on their pins");

  chk_irq_feed: assert property (
    @(posedge clk) disable iff (!rst_b)
    ($past(rst_b, 2) && $past(rst_b))
    |-> ({external_irq_one, external_irq_zero, capture_input_pin}
         == {$past(port_pin_in[GPD_BIT_IRQ1], 2),
             $past(port_pin_in[GPD_BIT_IRQ0], 2),
             $past(port_pin_in[GPD_BIT_CAPTURE], 2)}))
    else $error("interrupt or capture feed wrong");

  chk_no_override: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!usart_tx_en && !timer2_compare_en && !timer1_compare_a_en
     && !timer1_compare_b_en && !usart_rx_en)
    |-> (port_pin_out == port_output_latch
         && port_pin_oe == port_direction))
    else $error("override active with no function enabled");

  chk_reset_pins: assert property (
    @(posedge clk)
    !rst_b |-> (port_pin_oe == '0 && port_pin_pullup == '0))
    else $error("pins not released during reset");

  chk_latch_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_latch |=> (port_output_latch == $past(io_wdata)))
    else $error("latch write not stored");

  chk_sample_ro: assert property (
    @(posedge clk) disable iff (!rst_b)
    (io_wr && io_addr == GPD_OFS_PIN_SAMPLE)
    |=> ($stable(port_output_latch) && $stable(port_direction)))
    else $error("write to pin sample changed a register");

  chk_dir_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    (io_rd && io_addr == GPD_OFS_DIRECTION && !io_wr)
    |=> (io_rdata == $past(port_direction)))
    else $error("direction read returned wrong value");

  chk_compare_b: assert property (
    @(posedge clk) disable iff (!rst_b)
    (timer1_compare_b_en && port_direction[GPD_BIT_T1_CMPB])
    |-> (port_pin_oe[GPD_BIT_T1_CMPB]
         && port_pin_out[GPD_BIT_T1_CMPB] == timer1_compare_b_output))
    else $error("timer1 compare b not on its pin");

  chk_rdata_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    !io_rd |=> $stable(io_rdata))
    else $error("read data changed without a read");

endmodule : gpd_port

/* File: gpd_pkg.sv */
package gpd_pkg;

  // ----------------------------------------------------------------
  // register map of the port, byte offsets in the i/o space
  // ----------------------------------------------------------------
  localparam int GPD_ADDR_W = 6;
  localparam int GPD_DATA_W = 8;
  localparam logic [5:0] GPD_OFS_PIN_SAMPLE = 6'h10;
  localparam logic [5:0] GPD_OFS_DIRECTION = 6'h11;
  localparam logic [5:0] GPD_OFS_OUT_LATCH = 6'h12;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] GPD_RST_DIRECTION = 8'h00;
  localparam logic [7:0] GPD_RST_OUT_LATCH = 8'h00;
  localparam logic [7:0] GPD_RST_RDATA = 8'h00;
  localparam logic [7:0] GPD_UNMAPPED_RDATA = 8'h00;

  // ----------------------------------------------------------------
  // pin positions of the alternate functions
  // ----------------------------------------------------------------
  localparam int GPD_BIT_RXD = 0;
  localparam int GPD_BIT_TXD = 1;
  localparam int GPD_BIT_IRQ0 = 2;
  localparam int GPD_BIT_IRQ1 = 3;
  localparam int GPD_BIT_T1_CMPB = 4;
  localparam int GPD_BIT_T1_CMPA = 5;
  localparam int GPD_BIT_CAPTURE = 6;
  localparam int GPD_BIT_T2_CMP = 7;

  // ----------------------------------------------------------------
  // input synchroniser depth in clock cycles
  // ----------------------------------------------------------------
  localparam int GPD_SYNC_STAGES = 2;

endpackage : gpd_pkg

/* File: gpd_sync.sv */
`timescale 1ns/1ps

module gpd_sync
  import gpd_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int STAGES = GPD_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("gpd_sync: width must be at least one");
  end
  if (STAGES < 2) begin : g_bad_stages
    $error("gpd_sync: at least two stages are needed");
  end

  // ----------------------------------------------------------------
  // flop chain; only the next stage reads each stage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage [STAGES];

  // shift chain, first stage catches the pin level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign sync_out = stage[STAGES-1];

endmodule : gpd_sync

/* File: gpd_board.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// board circuits on the eight pads
// ----------------------------------------------------------------
module gpd_board (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_level
);
  logic [7:0] drift;

  // a floating pad shows a changing pattern, never a stale level
  initial drift = 8'h55;
  always @(posedge clk) begin
    drift <= ~drift;
  end

  // board drives only pads set as inputs; pull-up wins over floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else if (pin_pullup[i]) begin
        pin_level[i] = 1'b1;
      end else begin
        pin_level[i] = drift[i];
      end
    end
  end
endmodule : gpd_board

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top
  import gpd_pkg::*;
;
  logic clk, rst_b, io_wr, io_rd, gpd, tx_en, tx_d, rx_en, rx_d;
  logic t2_en, t2_o, ta_en, ta_o, tb_en, tb_o, cap, irq1, irq0;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata, p_in, p_out, p_oe, p_pu, ext_v, ext_e;
  int n_errors, checks;

  gpd_port u_dut (.clk(clk), .rst_b(rst_b), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .global_pullup_disable(gpd),
    .usart_tx_en(tx_en), .usart_tx_data(tx_d), .usart_rx_en(rx_en),
    .usart_rx_data(rx_d), .timer2_compare_en(t2_en),
    .timer2_compare_output(t2_o), .timer1_compare_a_en(ta_en),
    .timer1_compare_a_output(ta_o), .timer1_compare_b_en(tb_en),
    .timer1_compare_b_output(tb_o), .capture_input_pin(cap),
    .external_irq_one(irq1), .external_irq_zero(irq0),
    .port_pin_in(p_in), .port_pin_out(p_out), .port_pin_oe(p_oe),
    .port_pin_pullup(p_pu));

  gpd_board u_board (.clk(clk), .pin_out(p_out), .pin_oe(p_oe),
    .pin_pullup(p_pu), .ext_val(ext_v), .ext_en(ext_e), .pin_level(p_in));

  // ----------------------------------------------------------------
  // clock, shared bus cycles and compare
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(posedge clk) #1;
    io_wr = 1'b0;
  endtask : wr

  // read data is registered at the edge that takes the strobe
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    io_rd = 1'b1;
    io_addr = a;
    @(posedge clk) #1;
    io_rd = 1'b0;
    cmp8(io_rdata, exp);
  endtask : rd_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    cmp8(p_oe, 8'h00);
    rd_chk(GPD_OFS_DIRECTION, GPD_RST_DIRECTION);
    rd_chk(GPD_OFS_OUT_LATCH, GPD_RST_OUT_LATCH);
    wr(GPD_OFS_DIRECTION, 8'hA5);
    wr(GPD_OFS_OUT_LATCH, 8'h3C);
    wr(GPD_OFS_PIN_SAMPLE, 8'hFF);
    cmp8(p_oe, 8'hA5);
    cmp8(p_out & p_oe, 8'h24);
    rd_chk(GPD_OFS_DIRECTION, 8'hA5);
    rd_chk(GPD_OFS_OUT_LATCH, 8'h3C);
    rd_chk(6'h13, GPD_UNMAPPED_RDATA);
  endtask : t_regs

  task automatic t_pullup;
    wr(GPD_OFS_DIRECTION, 8'h0F);
    wr(GPD_OFS_OUT_LATCH, 8'hFF);
    cmp8(p_pu, 8'hF0);
    gpd = 1'b1;
    #1 cmp8(p_pu, 8'h00);
    @(posedge clk) #1;
    gpd = 1'b0;
    #1 cmp8(p_pu, 8'hF0);
    wr(GPD_OFS_OUT_LATCH, 8'h0F);
    cmp8(p_pu, 8'h00);
  endtask : t_pullup

  // pins must pass two flops before anyone sees them
  task automatic t_sync;
    wr(GPD_OFS_DIRECTION, 8'h00);
    ext_e = 8'hFF;
    ext_v = 8'h00;
    repeat (3) @(posedge clk);
    #1 ext_v = 8'h4C;
    @(posedge clk) #1;
    cmp8({5'h00, cap, irq1, irq0}, 8'h00);
    @(posedge clk) #1;
    cmp8({5'h00, cap, irq1, irq0}, 8'h07);
    rd_chk(GPD_OFS_PIN_SAMPLE, 8'h4C);
    ext_e = 8'h00;
  endtask : t_sync

  task automatic t_alt;
    wr(GPD_OFS_DIRECTION, 8'hB1);
    wr(GPD_OFS_OUT_LATCH, 8'h01);
    tx_en = 1'b1;
    tx_d = 1'b1;
    rx_en = 1'b1;
    t2_en = 1'b1;
    ta_en = 1'b1;
    tb_en = 1'b1;
    t2_o = 1'b1;
    ta_o = 1'b0;
    tb_o = 1'b1;
    #1 cmp8(p_oe, 8'hB2);
    cmp8(p_out & p_oe, 8'h92);
    cmp8({7'h00, p_pu[0]}, 8'h01);
    repeat (2) @(posedge clk);
    #1 cmp8({7'h00, rx_d}, 8'h01);
    ext_e = 8'h01;
    repeat (2) @(posedge clk);
    #1 cmp8({7'h00, rx_d}, 8'h00);
    ext_e = 8'h00;
    tx_d = 1'b0;
    ta_o = 1'b1;
    #1 cmp8(p_out & p_oe, 8'hB0);
    wr(GPD_OFS_DIRECTION, 8'h21);
    cmp8(p_oe, 8'h22);
    cmp8(p_out & p_oe, 8'h20);
    tx_en = 1'b0;
    rx_en = 1'b0;
    t2_en = 1'b0;
    ta_en = 1'b0;
    tb_en = 1'b0;
    #1 cmp8(p_oe, 8'h21);
    cmp8(p_out & p_oe, 8'h01);
  endtask : t_alt

  // reset between edges must release the pads at once
  task automatic t_reset;
    wr(GPD_OFS_DIRECTION, 8'hFF);
    #1.2 rst_b = 1'b0;
    #0.3 cmp8(p_oe, 8'h00);
    cmp8(p_pu, 8'h00);
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    rd_chk(GPD_OFS_DIRECTION, 8'h00);
  endtask : t_reset

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    #20000;
    n_errors++;
    finish_test();
  end

  initial begin
    {io_wr, io_rd, gpd, tx_en, tx_d, rx_en, t2_en, t2_o} = 8'h00;
    {ta_en, ta_o, tb_en, tb_o} = 4'h0;
    io_addr = 6'h00;
    io_wdata = 8'h00;
    ext_v = 8'h00;
    ext_e = 8'h00;
    n_errors = 0;
    checks = 0;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    t_regs();
    t_pullup();
    t_sync();
    t_alt();
    t_reset();
    finish_test();
  end
endmodule : tb_top
